// [hdl/fvc_defs.svh]
// Constants for the fixed reference control register
`ifndef FVC_DEFS_SVH
`define FVC_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FVC_ADDR_W          4
`define FVC_REF_CTRL_OFS    4'h0
`define FVC_REF_CTRL_RST    8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FVC_BIT_ENABLE      7
`define FVC_BIT_READY       6
`define FVC_BIT_TEMP_EN     5
`define FVC_BIT_TEMP_RNG    4
`define FVC_CMP_GAIN_HI     3
`define FVC_CMP_GAIN_LO     2
`define FVC_ADC_GAIN_HI     1
`define FVC_ADC_GAIN_LO     0

`endif

// [hdl/fvc_pkg.sv]
// Types shared by the fixed reference control logic
package fvc_pkg;

  // Gain selector codes, same for both paths
  typedef enum logic [1:0] {
    FVC_GAIN_OFF = 2'h0,
    FVC_GAIN_1X  = 2'h1,
    FVC_GAIN_2X  = 2'h2,
    FVC_GAIN_4X  = 2'h3
  } fvc_gain_t;

  // Ready tracking states, Gray along off -> settling -> ready
  typedef enum logic [1:0] {
    FVC_ST_OFF    = 2'h0,
    FVC_ST_SETTLE = 2'h1,
    FVC_ST_READY  = 2'h3
  } fvc_state_t;

endpackage

// [hdl/fvc_sync.sv]
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module fvc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // Next values; frozen while the enable is low
  always_comb begin
    meta_d = ce ? async_in : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// [hdl/fvc_gain_dec.sv]
// Registered one-hot decode of a gain selector code
`timescale 1ns/1ps
module fvc_gain_dec
  import fvc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [1:0] code,
  output logic [2:0]      sel_onehot
);
  logic [2:0] sel_q;
  logic [2:0] sel_d;

  // Off code drives no leg at all
  always_comb begin
    sel_d = sel_q;
    if (ce) begin
      unique case (fvc_gain_t'(code))
        FVC_GAIN_OFF: sel_d = 3'h0;
        FVC_GAIN_1X:  sel_d = 3'h1;
        FVC_GAIN_2X:  sel_d = 3'h2;
        FVC_GAIN_4X:  sel_d = 3'h4;
      endcase
    end
  end

  // Reset leaves the path off
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= 3'h0;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign sel_onehot = sel_q;
endmodule

// [hdl/fvc_top.sv]
// Fixed voltage reference control and status register
//
// Function
// [RULE_01] Bit 7 enables the fixed reference when one, disables it when zero.
// [RULE_02] Bit 6 is a read-only ready flag, one only when the output is usable.
// [RULE_03] On the standard-voltage variant the ready flag always reads one.
// [RULE_04] Bit 5 switches the temperature indicator on or off.
// [RULE_05] Bit 4 picks high temperature range when one, low range when zero.
// [RULE_06] Bits 3:2 set comparator/DAC gain: 11 4x, 10 2x, 01 1x, 00 off.
// [RULE_07] Bits 1:0 set converter gain independently, same code set.
// [RULE_08] All writable bits clear to zero on every reset.
// [RULE_09] Ready stays low after enabling until the analog circuits settle.
// [RULE_10] Writes to ready are ignored; it follows synchronised settle gated by enable.
`timescale 1ns/1ps
`include "fvc_defs.svh"
module fvc_top
  import fvc_pkg::*;
#(
  parameter bit STD_VOLTAGE = 1'b0
)(
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   CE,
  input  wire logic [`FVC_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]             WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic [7:0]                  RDATA,
  input  wire logic                   REF_SETTLED,
  output logic                        REFERENCE_ENABLE,
  output logic                        TEMP_INDICATOR_ENABLE,
  output logic                        TEMP_INDICATOR_RANGE,
  output logic [2:0]                  CMP_DAC_GAIN_ONEHOT,
  output logic [2:0]                  CONVERTER_GAIN_ONEHOT
);

  // ----------------------------------------------------------------
  // Writable fields
  // ----------------------------------------------------------------
  logic       enable_q;
  logic       enable_d;
  logic       temp_en_q;
  logic       temp_en_d;
  logic       temp_rng_q;
  logic       temp_rng_d;
  logic [1:0] cmp_gain_q;
  logic [1:0] cmp_gain_d;
  logic [1:0] adc_gain_q;
  logic [1:0] adc_gain_d;
  logic       hit_ctrl;

  assign hit_ctrl = (ADDR == `FVC_REF_CTRL_OFS);

  // Field updates on a write to the control word
  always_comb begin
    enable_d   = enable_q;
    temp_en_d  = temp_en_q;
    temp_rng_d = temp_rng_q;
    cmp_gain_d = cmp_gain_q;
    adc_gain_d = adc_gain_q;
    if (CE && WR && hit_ctrl) begin
      enable_d   = WDATA[`FVC_BIT_ENABLE];                      // [RULE_01]
      temp_en_d  = WDATA[`FVC_BIT_TEMP_EN];                     // [RULE_04]
      temp_rng_d = WDATA[`FVC_BIT_TEMP_RNG];                    // [RULE_05]
      cmp_gain_d = WDATA[`FVC_CMP_GAIN_HI:`FVC_CMP_GAIN_LO];    // [RULE_06]
      adc_gain_d = WDATA[`FVC_ADC_GAIN_HI:`FVC_ADC_GAIN_LO];    // [RULE_07]
    end
  end

  // Every reset returns the writable bits to zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      enable_q   <= 1'(`FVC_REF_CTRL_RST >> `FVC_BIT_ENABLE);   // [RULE_08]
      temp_en_q  <= 1'b0;
      temp_rng_q <= 1'b0;
      cmp_gain_q <= 2'h0;
      adc_gain_q <= 2'h0;
    end else begin
      enable_q   <= enable_d;
      temp_en_q  <= temp_en_d;
      temp_rng_q <= temp_rng_d;
      cmp_gain_q <= cmp_gain_d;
      adc_gain_q <= adc_gain_d;
    end
  end

  // ----------------------------------------------------------------
  // Ready tracking
  // ----------------------------------------------------------------
  logic       settled_sync;
  fvc_state_t state_q;
  fvc_state_t state_d;

  // Analog settle level comes from outside the clock domain
  fvc_sync u_settle_sync (
    .clk      (CLK),
    .rst      (SYS_RST),
    .ce       (CE),
    .async_in (REF_SETTLED),
    .sync_out (settled_sync)
  );

  // Disable drops ready at once; a stale settle level is not trusted
  always_comb begin
    state_d = state_q;
    if (CE) begin
      unique case (state_q)
        FVC_ST_OFF:    if (enable_q) state_d = FVC_ST_SETTLE;           // [RULE_09]
        FVC_ST_SETTLE: begin
          if (!enable_q) state_d = FVC_ST_OFF;
          else if (settled_sync) state_d = FVC_ST_READY;                // [RULE_10]
        end
        FVC_ST_READY: begin
          if (!enable_q) state_d = FVC_ST_OFF;
          else if (!settled_sync) state_d = FVC_ST_SETTLE;
        end
        default:       state_d = FVC_ST_OFF;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q <= FVC_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  logic ready;
  // Standard-voltage parts report ready unconditionally
  assign ready = STD_VOLTAGE ? 1'b1 : (state_q == FVC_ST_READY);       // [RULE_02] [RULE_03]

  // ----------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       ref_en_q;
  logic       ref_en_d;
  logic       ind_en_q;
  logic       ind_en_d;
  logic       ind_rng_q;
  logic       ind_rng_d;

  // Read data valid the cycle after the strobe, then held only while CE is low; unmapped reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (CE && RD && hit_ctrl) begin
      rdata_d = {enable_q, ready, temp_en_q, temp_rng_q, cmp_gain_q, adc_gain_q};
    end else if (!CE) begin
      rdata_d = rdata_q;
    end
  end

  // Side outputs lag the register by one cycle so pins never glitch on a write
  always_comb begin
    ref_en_d  = CE ? enable_q : ref_en_q;                              // [RULE_01]
    ind_en_d  = CE ? temp_en_q : ind_en_q;                             // [RULE_04]
    ind_rng_d = CE ? temp_rng_q : ind_rng_q;                           // [RULE_05]
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_q   <= 8'h00;
      ref_en_q  <= 1'b0;
      ind_en_q  <= 1'b0;
      ind_rng_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      ref_en_q  <= ref_en_d;
      ind_en_q  <= ind_en_d;
      ind_rng_q <= ind_rng_d;
    end
  end

  // Gain legs; one-hot so the analog switch never shorts two taps
  fvc_gain_dec u_cmp_gain (
    .clk        (CLK),
    .rst        (SYS_RST),
    .ce         (CE),
    .code       (cmp_gain_q),
    .sel_onehot (CMP_DAC_GAIN_ONEHOT)
  );                                                                    // [RULE_06]

  fvc_gain_dec u_adc_gain (
    .clk        (CLK),
    .rst        (SYS_RST),
    .ce         (CE),
    .code       (adc_gain_q),
    .sel_onehot (CONVERTER_GAIN_ONEHOT)
  );                                                                    // [RULE_07]

  assign RDATA                 = rdata_q;
  assign REFERENCE_ENABLE      = ref_en_q;
  assign TEMP_INDICATOR_ENABLE = ind_en_q;
  assign TEMP_INDICATOR_RANGE  = ind_rng_q;

endmodule

// [bench/fvc_checker.sv]
// Port checker for the reference control register
`timescale 1ns/1ps
module fvc_checker
  import fvc_pkg::*;
#(
  parameter bit STD_VOLTAGE = 1'b0
)(
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       CE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       REFERENCE_ENABLE,
  input wire logic       TEMP_INDICATOR_ENABLE,
  input wire logic       TEMP_INDICATOR_RANGE,
  input wire logic [2:0] CMP_DAC_GAIN_ONEHOT,
  input wire logic [2:0] CONVERTER_GAIN_ONEHOT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Gain code to one-hot, code 00 means path off
  function automatic logic [2:0] oh(input logic [1:0] c);
    return 3'(4'h1 << c >> 1);
  endfunction
  wire logic rd0 = CE && RD && ADDR == 4'h0;
  // Write accepted, then one more enabled cycle to reach the side outputs
  sequence s_wr;
    CE && WR && ADDR == 4'h0 ##1 CE;
  endsequence
  // Side outputs follow the written fields two cycles on
  property p_en; s_wr |=> REFERENCE_ENABLE == $past(WDATA[7], 2); endproperty
  a_en: assert property (p_en) else $error("enable output wrong");
  property p_temp_en; s_wr |=> TEMP_INDICATOR_ENABLE == $past(WDATA[5], 2); endproperty
  a_temp_en: assert property (p_temp_en) else $error("temp enable wrong");
  property p_temp_rng; s_wr |=> TEMP_INDICATOR_RANGE == $past(WDATA[4], 2); endproperty
  a_temp_rng: assert property (p_temp_rng) else $error("temp range wrong");
  property p_cmp; s_wr |=> CMP_DAC_GAIN_ONEHOT == oh($past(WDATA[3:2], 2)); endproperty
  a_cmp: assert property (p_cmp) else $error("cmp gain wrong");
  property p_adc; s_wr |=> CONVERTER_GAIN_ONEHOT == oh($past(WDATA[1:0], 2)); endproperty
  a_adc: assert property (p_adc) else $error("adc gain wrong");
  // Read data must agree with what the outputs show
  property p_rdbk; rd0 |=> RDATA[7] == REFERENCE_ENABLE && RDATA[5:4] == {TEMP_INDICATOR_ENABLE, TEMP_INDICATOR_RANGE}
    && CMP_DAC_GAIN_ONEHOT == oh(RDATA[3:2]) && CONVERTER_GAIN_ONEHOT == oh(RDATA[1:0]); endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback differs");
  // Ready reads zero while the reference has been off for two cycles, and one on the standard-voltage variant
  property p_rdy; rd0 && !REFERENCE_ENABLE && !$past(REFERENCE_ENABLE) |=> RDATA[6] == STD_VOLTAGE; endproperty
  a_rdy: assert property (p_rdy) else $error("ready while off");
  property p_rst; $fell(SYS_RST) |-> RDATA == 8'h00 && !REFERENCE_ENABLE && !TEMP_INDICATOR_ENABLE
    && !TEMP_INDICATOR_RANGE && CMP_DAC_GAIN_ONEHOT == 3'h0 && CONVERTER_GAIN_ONEHOT == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("not cleared by reset");
endmodule
bind fvc_top fvc_checker #(.STD_VOLTAGE(STD_VOLTAGE)) fvc_checker_inst (.CLK, .SYS_RST, .CE, .ADDR, .WDATA, .WR,
  .RD, .RDATA, .REFERENCE_ENABLE, .TEMP_INDICATOR_ENABLE, .TEMP_INDICATOR_RANGE, .CMP_DAC_GAIN_ONEHOT,
  .CONVERTER_GAIN_ONEHOT);

// [bench/fvc_tb_top.sv]
// Self-checking bench for the reference control register
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end
module fvc_tb_top
  import fvc_pkg::*;
;
  logic       clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, settled = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, rdata_s, v;
  logic       ren, ten, trg;
  logic [2:0] cmp, adc;
  int         failures = 0, compares = 0;
  always #4 clk = ~clk;
  // Main instance, plus a standard-voltage one sharing the bus
  fvc_top fvc_top_inst (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .REF_SETTLED(settled), .REFERENCE_ENABLE(ren), .TEMP_INDICATOR_ENABLE(ten),
    .TEMP_INDICATOR_RANGE(trg), .CMP_DAC_GAIN_ONEHOT(cmp), .CONVERTER_GAIN_ONEHOT(adc));
  fvc_top #(.STD_VOLTAGE(1'b1)) fvc_top_std_inst (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata_s), .REF_SETTLED(settled), .REFERENCE_ENABLE(),
    .TEMP_INDICATOR_ENABLE(), .TEMP_INDICATOR_RANGE(), .CMP_DAC_GAIN_ONEHOT(), .CONVERTER_GAIN_ONEHOT());
  function automatic logic [2:0] oh(input logic [1:0] c);
    return 3'(4'h1 << c >> 1);
  endfunction
  // Bus cycles; a one-cycle gap between calls keeps strobes single
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // Standard variant must show ready set on every mapped read
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
    `CHK(rdata_s, (a == 4'h0) ? (e | 8'h40) : 8'h00)
    // Return on a rising edge so callers drive the next inputs there
    @(posedge clk);
  endtask
  task automatic out_check(input logic [7:0] e);
    @(posedge clk);
    @(negedge clk);
    `CHK({ren, ten, trg, cmp, adc}, {e[7], e[5], e[4], oh(e[3:2]), oh(e[1:0])})
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 120 cycles the tests need
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    reg_read(4'h0, 8'h00);
    // Every gain code on both paths, ready bit written but ignored
    for (int k = 0; k < 4; k++) begin
      v = {k[0], 1'b0, k[1], k[0], k[1:0], 2'(3 - k)};
      reg_write(4'h0, v | 8'h40);
      out_check(v);
      reg_read(4'h0, v);
    end
    reg_write(4'h5, 8'h00);
    reg_read(4'h5, 8'h00);
    ce <= 1'b0;
    reg_write(4'h0, 8'h00);
    ce <= 1'b1;
    reg_read(4'h0, 8'hbc);
    // Settle indication must pass the synchroniser first
    settled <= 1'b1;
    reg_read(4'h0, 8'hbc);
    repeat (8) @(posedge clk);
    reg_read(4'h0, 8'hfc);
    settled <= 1'b0;
    repeat (8) @(posedge clk);
    reg_read(4'h0, 8'hbc);
    settled <= 1'b1;
    repeat (8) @(posedge clk);
    reg_write(4'h0, 8'h3c);
    repeat (2) @(posedge clk);
    reg_read(4'h0, 8'h3c);
    // Re-enable with settle already high: one settling cycle, then ready
    reg_write(4'h0, 8'hbc);
    reg_read(4'h0, 8'hbc);
    reg_read(4'h0, 8'hfc);
    // Reset in mid-run clears everything written
    reg_write(4'h0, 8'hbf);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    out_check(8'h00);
    reg_read(4'h0, 8'h00);
    finish_test();
  end
endmodule
